// ---- logic/motor_speed_consts.svh ----
`ifndef MOTOR_SPEED_CONSTS_SVH
`define MOTOR_SPEED_CONSTS_SVH

// ****************************************
// Command format
// ****************************************
`define CMD_FULL 16'h8000
`define GAIN_SHIFT 12
`define REF_SHIFT 15

// ****************************************
// Register byte offsets
// ****************************************
`define ADDR_CTRL 8'h00
`define ADDR_SERIAL_CMD 8'h04
`define ADDR_STOP_THR 8'h08
`define ADDR_MIN_DUTY 8'h0C
`define ADDR_ENTRY_LVL 8'h10
`define ADDR_EXIT_LVL 8'h14
`define ADDR_FULL_LVL 8'h18
`define ADDR_GAIN 8'h1C
`define ADDR_MAX_SPEED 8'h20
`define ADDR_MAX_POWER 8'h24
`define ADDR_ACCEL 8'h28
`define ADDR_STATUS 8'h2C
`define ADDR_REF 8'h30
`define ADDR_DUTY_OUT 8'h34

// ****************************************
// Control field positions
// ****************************************
`define CTRL_SRC_LSB 0
`define CTRL_LOOP_LSB 2
`define CTRL_SURGE_BIT 4

// ****************************************
// Reset values
// ****************************************
`define RST_CTRL 5'h00
`define RST_SERIAL_CMD 16'h0000
`define RST_STOP_THR 16'h0400
`define RST_MIN_DUTY 16'h0800
`define RST_ENTRY_LVL 16'h0200
`define RST_EXIT_LVL 16'h0400
`define RST_FULL_LVL 16'h8000
`define RST_GAIN 16'h1000
`define RST_MAX_SPEED 16'h0100
`define RST_MAX_POWER 16'h0100
`define RST_ACCEL 16'h0040

// ****************************************
// Timing
// ****************************************
`define CLK_PERIOD_NS 4
`define ACCEL_TICK_NS 1000

`endif

// ---- logic/motor_speed_pkg.sv ----
package motor_speed_pkg;

  typedef enum logic [1:0] {
    SRC_ANALOG = 2'b00,
    SRC_PWM = 2'b01,
    SRC_SERIAL = 2'b10,
    SRC_FREQ = 2'b11
  } cmd_source_t;

  typedef enum logic [1:0] {
    LOOP_OPEN = 2'b00,
    LOOP_SPEED = 2'b01,
    LOOP_POWER = 2'b10,
    LOOP_RSVD = 2'b11
  } loop_select_t;

  typedef struct packed {
    logic [15:0] entry;
    logic [15:0] exit;
    logic [15:0] full_scale;
    logic [15:0] gain;
  } level_cfg_t;

  typedef struct packed {
    logic wr;
    logic rd;
    logic [7:0] addr;
    logic [31:0] wdata;
  } reg_req_t;

endpackage

// ---- logic/pin_command_scaler.sv ----
`timescale 1ns/1ps
`include "motor_speed_consts.svh"

module pin_command_scaler (
  input wire logic ref_clk_i,
  input wire logic reset_n_i,
  input wire logic [15:0] level_i,
  input wire motor_speed_pkg::level_cfg_t cfg_i,
  output logic [15:0] cmd_o,
  output logic running_o
);

  logic running_ff;
  logic [15:0] cmd_ff;
  wire [31:0] product = level_i * cfg_i.gain;
  wire [31:0] scaled = product >> `GAIN_SHIFT;
  wire over_full = (level_i >= cfg_i.full_scale) ||
                   (scaled > {16'h0000, `CMD_FULL});
  wire [15:0] linear_cmd = over_full ? `CMD_FULL : scaled[15:0];
  // Dead band keeps the old decision so a noisy pin cannot chatter
  wire nxt_running = (level_i <= cfg_i.entry) ? 1'b0 :
                     (level_i >= cfg_i.exit) ? 1'b1 :
                     running_ff;
  wire [15:0] nxt_cmd = nxt_running ? linear_cmd : 16'h0000;

  always_ff @(posedge ref_clk_i) begin
    if (!reset_n_i) begin
      running_ff <= 1'b0;
      cmd_ff <= 16'h0000;
    end else begin
      running_ff <= nxt_running;
      cmd_ff <= nxt_cmd;
    end
  end

  assign cmd_o = cmd_ff;
  assign running_o = running_ff;

endmodule

// ---- logic/motor_speed_command_mapper.sv ----
`timescale 1ns/1ps
`include "motor_speed_consts.svh"

// How it works
// - One of four sources drives the command, per command_source_select.
// - Loop 00b: duty target follows command, floored at minimum fraction.
// - Loop 01b: speed reference is command times full-scale speed, floored.
// - Loop 10b: power reference is command times full-scale power, floored.
// - Command below stop_command_threshold: reference zero, motor stopped.
// - Applied duty settles on target; surge guard and accel only shape ramps.
// - Analog mode: pin at or below standby entry level gives zero command.
// - Analog mode: linear above standby exit level, clamped at full scale.
// - Source 01b decodes pin duty linearly into the duty command.
// - Source 10b takes the serially written speed command register.
// - Source 11b decodes pin frequency linearly, clamped at full scale.
module motor_speed_command_mapper #(
  parameter int TICK_CYCLES =
    (`ACCEL_TICK_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS
) (
  input wire logic ref_clk_i,
  input wire logic reset_n_i,
  input wire logic [7:0] reg_addr_i,
  input wire logic [31:0] reg_wdata_i,
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  output logic [31:0] reg_rdata_o,
  input wire logic [15:0] pin_level_i,
  input wire logic [15:0] pin_duty_i,
  input wire logic [15:0] pin_freq_i,
  output logic [15:0] duty_cmd_o,
  output logic [31:0] active_ref_o,
  output logic [15:0] duty_out_o,
  output logic motor_stopped_o
);

  // ****************************************
  // Helpers
  // ****************************************
  function automatic logic hit(input logic [7:0] a, input logic [7:0] off);
    hit = (a == off);
  endfunction

  function automatic logic [31:0] q15_scale(input logic [15:0] frac,
                                            input logic [15:0] full);
    logic [31:0] p;
    p = frac * full;
    q15_scale = p >> `REF_SHIFT;
  endfunction

  // ****************************************
  // Register bus
  // ****************************************
  motor_speed_pkg::reg_req_t req;
  assign req = '{wr: reg_wr_i, rd: reg_rd_i, addr: reg_addr_i,
                 wdata: reg_wdata_i};

  logic [4:0] ctrl_ff;
  logic [15:0] serial_cmd_ff;
  logic [15:0] stop_thr_ff;
  logic [15:0] min_duty_ff;
  logic [15:0] entry_ff;
  logic [15:0] exit_ff;
  logic [15:0] full_ff;
  logic [15:0] gain_ff;
  logic [15:0] max_speed_ff;
  logic [15:0] max_power_ff;
  logic [15:0] accel_ff;
  logic [31:0] rdata_ff;

  wire [15:0] wd16 = req.wdata[15:0];

  always_ff @(posedge ref_clk_i) begin
    if (!reset_n_i) begin
      ctrl_ff <= `RST_CTRL;
      serial_cmd_ff <= `RST_SERIAL_CMD;
      stop_thr_ff <= `RST_STOP_THR;
      min_duty_ff <= `RST_MIN_DUTY;
      entry_ff <= `RST_ENTRY_LVL;
      exit_ff <= `RST_EXIT_LVL;
      full_ff <= `RST_FULL_LVL;
      gain_ff <= `RST_GAIN;
      max_speed_ff <= `RST_MAX_SPEED;
      max_power_ff <= `RST_MAX_POWER;
      accel_ff <= `RST_ACCEL;
    end else if (req.wr) begin
      if (hit(req.addr, `ADDR_CTRL)) ctrl_ff <= req.wdata[4:0];
      if (hit(req.addr, `ADDR_SERIAL_CMD)) serial_cmd_ff <= wd16;
      if (hit(req.addr, `ADDR_STOP_THR)) stop_thr_ff <= wd16;
      if (hit(req.addr, `ADDR_MIN_DUTY)) min_duty_ff <= wd16;
      if (hit(req.addr, `ADDR_ENTRY_LVL)) entry_ff <= wd16;
      if (hit(req.addr, `ADDR_EXIT_LVL)) exit_ff <= wd16;
      if (hit(req.addr, `ADDR_FULL_LVL)) full_ff <= wd16;
      if (hit(req.addr, `ADDR_GAIN)) gain_ff <= wd16;
      if (hit(req.addr, `ADDR_MAX_SPEED)) max_speed_ff <= wd16;
      if (hit(req.addr, `ADDR_MAX_POWER)) max_power_ff <= wd16;
      if (hit(req.addr, `ADDR_ACCEL)) accel_ff <= wd16;
    end
  end

  wire motor_speed_pkg::cmd_source_t src_sel =
    motor_speed_pkg::cmd_source_t'(ctrl_ff[`CTRL_SRC_LSB +: 2]);
  wire motor_speed_pkg::loop_select_t loop_sel =
    motor_speed_pkg::loop_select_t'(ctrl_ff[`CTRL_LOOP_LSB +: 2]);
  wire surge_guard_on = ctrl_ff[`CTRL_SURGE_BIT];

  // ****************************************
  // Command source
  // ****************************************
  motor_speed_pkg::level_cfg_t level_cfg;
  assign level_cfg = '{entry: entry_ff, exit: exit_ff,
                       full_scale: full_ff, gain: gain_ff};

  logic [15:0] pin_value;
  always_comb begin
    unique case (src_sel)
      motor_speed_pkg::SRC_ANALOG: pin_value = pin_level_i;
      motor_speed_pkg::SRC_PWM: pin_value = pin_duty_i;
      motor_speed_pkg::SRC_SERIAL: pin_value = 16'h0000;
      motor_speed_pkg::SRC_FREQ: pin_value = pin_freq_i;
    endcase
  end

  logic [15:0] pin_cmd;
  pin_command_scaler u_scaler (
    .ref_clk_i(ref_clk_i),
    .reset_n_i(reset_n_i),
    .level_i(pin_value),
    .cfg_i(level_cfg),
    .cmd_o(pin_cmd),
    .running_o()
  );

  wire [15:0] serial_cmd = (serial_cmd_ff > `CMD_FULL) ? `CMD_FULL :
                           serial_cmd_ff;
  wire [15:0] nxt_duty_cmd = (src_sel == motor_speed_pkg::SRC_SERIAL) ?
                             serial_cmd : pin_cmd;

  // ****************************************
  // Reference mapping
  // ****************************************
  logic [15:0] duty_cmd_ff;
  logic [31:0] ref_ff;
  logic stopped_ff;
  logic [15:0] duty_out_ff;

  wire below_stop = duty_cmd_ff < stop_thr_ff;
  // Dead zone between stop threshold and minimum is held at the minimum
  wire [15:0] floored_cmd = (duty_cmd_ff < min_duty_ff) ? min_duty_ff :
                            duty_cmd_ff;

  logic [31:0] mapped_ref;
  always_comb begin
    unique case (loop_sel)
      motor_speed_pkg::LOOP_SPEED:
        mapped_ref = q15_scale(floored_cmd, max_speed_ff);
      motor_speed_pkg::LOOP_POWER:
        mapped_ref = q15_scale(floored_cmd, max_power_ff);
      motor_speed_pkg::LOOP_OPEN,
      motor_speed_pkg::LOOP_RSVD:
        mapped_ref = {16'h0000, floored_cmd};
    endcase
  end

  wire [31:0] nxt_ref = below_stop ? 32'h0000_0000 : mapped_ref;
  // Closed loops have no plant model here, so the floored command is
  // taken as the duty that the loop settles on
  wire [15:0] duty_target = below_stop ? 16'h0000 : floored_cmd;

  // ****************************************
  // Applied duty ramp
  // ****************************************
  localparam int TICK_W = $clog2(TICK_CYCLES + 1);
  logic [TICK_W-1:0] tick_cnt_ff;
  wire tick = (tick_cnt_ff == TICK_W'(TICK_CYCLES - 1));
  wire [TICK_W-1:0] nxt_tick_cnt = tick ? '0 : tick_cnt_ff + 1'b1;

  wire rising = duty_target > duty_out_ff;
  wire falling = duty_target < duty_out_ff;
  wire [15:0] gap_up = duty_target - duty_out_ff;
  wire [15:0] gap_dn = duty_out_ff - duty_target;
  wire [15:0] up_val = (gap_up > accel_ff) ? duty_out_ff + accel_ff :
                       duty_target;
  // Surge guard slows the fall so braking energy cannot pump the supply
  wire [15:0] dn_val = (surge_guard_on && gap_dn > accel_ff) ?
                       duty_out_ff - accel_ff : duty_target;
  wire [15:0] nxt_duty_out = !tick ? duty_out_ff :
                             rising ? up_val :
                             falling ? dn_val : duty_out_ff;

  // ****************************************
  // Read back
  // ****************************************
  logic [31:0] rd_mux;
  always_comb begin
    rd_mux = 32'h0000_0000;
    if (hit(req.addr, `ADDR_CTRL)) rd_mux = {27'h0, ctrl_ff};
    if (hit(req.addr, `ADDR_SERIAL_CMD)) rd_mux = {16'h0, serial_cmd_ff};
    if (hit(req.addr, `ADDR_STOP_THR)) rd_mux = {16'h0, stop_thr_ff};
    if (hit(req.addr, `ADDR_MIN_DUTY)) rd_mux = {16'h0, min_duty_ff};
    if (hit(req.addr, `ADDR_ENTRY_LVL)) rd_mux = {16'h0, entry_ff};
    if (hit(req.addr, `ADDR_EXIT_LVL)) rd_mux = {16'h0, exit_ff};
    if (hit(req.addr, `ADDR_FULL_LVL)) rd_mux = {16'h0, full_ff};
    if (hit(req.addr, `ADDR_GAIN)) rd_mux = {16'h0, gain_ff};
    if (hit(req.addr, `ADDR_MAX_SPEED)) rd_mux = {16'h0, max_speed_ff};
    if (hit(req.addr, `ADDR_MAX_POWER)) rd_mux = {16'h0, max_power_ff};
    if (hit(req.addr, `ADDR_ACCEL)) rd_mux = {16'h0, accel_ff};
    if (hit(req.addr, `ADDR_STATUS)) begin
      rd_mux = {15'h0, stopped_ff, duty_cmd_ff};
    end
    if (hit(req.addr, `ADDR_REF)) rd_mux = ref_ff;
    if (hit(req.addr, `ADDR_DUTY_OUT)) rd_mux = {16'h0, duty_out_ff};
  end

  wire [31:0] nxt_rdata = req.rd ? rd_mux : 32'h0000_0000;

  always_ff @(posedge ref_clk_i) begin
    if (!reset_n_i) begin
      duty_cmd_ff <= 16'h0000;
      ref_ff <= 32'h0000_0000;
      stopped_ff <= 1'b1;
      duty_out_ff <= 16'h0000;
      tick_cnt_ff <= '0;
      rdata_ff <= 32'h0000_0000;
    end else begin
      duty_cmd_ff <= nxt_duty_cmd;
      ref_ff <= nxt_ref;
      stopped_ff <= below_stop;
      duty_out_ff <= nxt_duty_out;
      tick_cnt_ff <= nxt_tick_cnt;
      rdata_ff <= nxt_rdata;
    end
  end

  assign reg_rdata_o = rdata_ff;
  assign duty_cmd_o = duty_cmd_ff;
  assign active_ref_o = ref_ff;
  assign duty_out_o = duty_out_ff;
  assign motor_stopped_o = stopped_ff;

endmodule

// ---- dv/speed_pin_source.sv ----
`timescale 1ns/1ps
// ****
// Speed pin controller model
// ****
module speed_pin_source (
  input wire logic ref_clk_i,
  input wire logic [15:0] level_i,
  input wire logic [15:0] duty_i,
  input wire logic [15:0] freq_i,
  output logic [15:0] pin_level_o,
  output logic [15:0] pin_duty_o,
  output logic [15:0] pin_freq_o
);
  // Pins move only after an edge, as a real decoder output would
  always_ff @(posedge ref_clk_i) begin
    pin_level_o <= level_i;
    pin_duty_o <= duty_i;
    pin_freq_o <= freq_i;
  end
endmodule

// ---- dv/speed_map_monitor.sv ----
`timescale 1ns/1ps
// ****
// Port checks
// ****
module speed_map_monitor #(
  parameter int TICK_CYCLES = 4
) (
  input wire logic ref_clk_i,
  input wire logic reset_n_i,
  input wire logic reg_rd_i,
  input wire logic [31:0] reg_rdata_o,
  input wire logic [15:0] duty_cmd_o,
  input wire logic [31:0] active_ref_o,
  input wire logic [15:0] duty_out_o,
  input wire logic motor_stopped_o
);
  default clocking cb @(posedge ref_clk_i);
  endclocking
  default disable iff (!reset_n_i);
  chk_rdata_idle: assert property (!$past(reg_rd_i) |-> reg_rdata_o == 0)
    else $error("read data outside slot");
  chk_stop_zero: assert property (motor_stopped_o |-> active_ref_o == 0)
    else $error("reference not zero when stopped");
  // Threshold kept at its reset value by the bench
  chk_stop_thr: assert property (
    motor_stopped_o == ($past(duty_cmd_o) < 16'h0400))
    else $error("stop flag wrong");
  chk_cmd_clamp: assert property (duty_cmd_o <= 16'h8000)
    else $error("command above full scale");
  chk_duty_clamp: assert property (duty_out_o <= 16'h8000)
    else $error("duty above full scale");
  chk_stop_norise: assert property (
    motor_stopped_o [*2] |-> duty_out_o <= $past(duty_out_o))
    else $error("duty rose while stopped");
  chk_ramp_step: assert property (duty_out_o > $past(duty_out_o) |->
    duty_out_o - $past(duty_out_o) <= 16'h0040)
    else $error("rise step too large");
  // Holds for any tick period of four cycles or more
  chk_ramp_tick: assert property (
    $changed(duty_out_o) |=> $stable(duty_out_o) [*3])
    else $error("duty moved between ticks");
  cov_start: cover property ($fell(motor_stopped_o));
  cov_read: cover property (reg_rd_i ##1 reg_rdata_o != 0);
  cov_full: cover property (duty_cmd_o == 16'h8000);
endmodule

bind motor_speed_command_mapper speed_map_monitor #(
  .TICK_CYCLES(TICK_CYCLES)
) u_speed_map_monitor (
  .ref_clk_i(ref_clk_i),
  .reset_n_i(reset_n_i),
  .reg_rd_i(reg_rd_i),
  .reg_rdata_o(reg_rdata_o),
  .duty_cmd_o(duty_cmd_o),
  .active_ref_o(active_ref_o),
  .duty_out_o(duty_out_o),
  .motor_stopped_o(motor_stopped_o)
);

// ---- dv/tb_top.sv ----
`timescale 1ns/1ps
`include "motor_speed_consts.svh"
// ****
// Bench
// ****
module tb_top;
  logic ref_clk_i = 1'b0;
  logic reset_n_i = 1'b0;
  logic [7:0] addr = 8'h00;
  logic [31:0] wdata = 32'h0000_0000;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic [15:0] lv = 16'h0000;
  logic [15:0] dt = 16'h0000;
  logic [15:0] fq = 16'h0000;
  logic [15:0] p_lv, p_dt, p_fq, duty_cmd, duty_out;
  logic [31:0] rdata, act_ref;
  logic stopped;
  logic rd_seen = 1'b0;
  logic [31:0] exp_q[$];
  int n_mismatch = 0;
  int checks = 0;
  logic [15:0] v, d, f;
  logic [31:0] tbl[4];
  logic [31:0] rst_v[11] = '{`RST_CTRL, `RST_SERIAL_CMD, `RST_STOP_THR,
    `RST_MIN_DUTY, `RST_ENTRY_LVL, `RST_EXIT_LVL, `RST_FULL_LVL,
    `RST_GAIN, `RST_MAX_SPEED, `RST_MAX_POWER, `RST_ACCEL};
  logic [31:0] hi_v[4] = '{32'h4000, 32'h0080, 32'h0100, 32'h4000};
  logic [31:0] lo_v[4] = '{32'h0800, 32'h0010, 32'h0020, 32'h0800};
  always #2 ref_clk_i = ~ref_clk_i;
  speed_pin_source u_speed_pin_source (.ref_clk_i(ref_clk_i),
    .level_i(lv), .duty_i(dt), .freq_i(fq), .pin_level_o(p_lv),
    .pin_duty_o(p_dt), .pin_freq_o(p_fq));
  // Short ramp tick keeps the duty settling waits small
  motor_speed_command_mapper #(.TICK_CYCLES(4))
    u_motor_speed_command_mapper (.ref_clk_i(ref_clk_i),
    .reset_n_i(reset_n_i), .reg_addr_i(addr), .reg_wdata_i(wdata),
    .reg_wr_i(wr), .reg_rd_i(rd), .reg_rdata_o(rdata),
    .pin_level_i(p_lv), .pin_duty_i(p_dt), .pin_freq_i(p_fq),
    .duty_cmd_o(duty_cmd), .active_ref_o(act_ref),
    .duty_out_o(duty_out), .motor_stopped_o(stopped));
  task automatic idle(input int n);
    wr <= 1'b0;
    rd <= 1'b0;
    repeat (n) @(posedge ref_clk_i);
  endtask
  task automatic wr_reg(input logic [7:0] a, input logic [31:0] x);
    addr <= a;
    wdata <= x;
    wr <= 1'b1;
    rd <= 1'b0;
    @(posedge ref_clk_i);
  endtask
  task automatic rd_chk(input logic [7:0] a, input logic [31:0] e);
    exp_q.push_back(e);
    addr <= a;
    wr <= 1'b0;
    rd <= 1'b1;
    @(posedge ref_clk_i);
  endtask
  task automatic pins(input logic [15:0] l, input logic [15:0] y,
                      input logic [15:0] z);
    lv <= l;
    dt <= y;
    fq <= z;
    idle(8);
  endtask
  task automatic port_chk(input logic [31:0] got, input logic [31:0] e);
    checks++;
    if (got !== e) begin
      n_mismatch++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, e);
    end
  endtask
  function automatic logic [31:0] st(input logic [15:0] c, input logic s);
    return {15'h0000, s, c};
  endfunction
  always @(posedge ref_clk_i) begin
    rd_seen <= rd;
    if (rd_seen) begin
      checks++;
      if (exp_q.size() == 0 || rdata !== exp_q[0]) begin
        n_mismatch++;
        $display("BAD t=%0t got=%h exp=%h", $time, rdata, exp_q[0]);
      end
      if (exp_q.size() > 0) void'(exp_q.pop_front());
    end
  end
  task automatic report_and_stop();
    if (n_mismatch == 0 && checks > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask
  initial begin
    void'($urandom(33));
    repeat (16) @(posedge ref_clk_i);
    reset_n_i <= 1'b1;
    idle(2);
    for (int i = 0; i < 11; i++) rd_chk(8'(4 * i), rst_v[i]);
    rd_chk(8'h3C, 32'h0000_0000);
    pins(16'h0100, 16'h0000, 16'h0000);
    rd_chk(`ADDR_STATUS, st(16'h0000, 1'b1));
    pins(16'h0300, 16'h0000, 16'h0000);
    rd_chk(`ADDR_STATUS, st(16'h0000, 1'b1));
    rd_chk(`ADDR_REF, 32'h0000_0000);
    for (int i = 0; i < 4; i++) begin
      v = 16'h0400 + 16'($urandom % 32'h7C00);
      pins(v, 16'h0000, 16'h0000);
      rd_chk(`ADDR_STATUS, st(v, 1'b0));
      rd_chk(`ADDR_REF, (v < 16'h0800) ? 32'h0800 : 32'(v));
    end
    pins(16'h0300, 16'h0000, 16'h0000);
    rd_chk(`ADDR_STATUS, st(16'h0300, 1'b1));
    pins(16'h9000, 16'h0000, 16'h0000);
    rd_chk(`ADDR_STATUS, st(16'h8000, 1'b0));
    wr_reg(`ADDR_MAX_POWER, 32'h0000_0200);
    for (int m = 0; m < 4; m++) begin
      wr_reg(`ADDR_CTRL, 32'(m) << `CTRL_LOOP_LSB);
      pins(16'h4000, 16'h0000, 16'h0000);
      rd_chk(`ADDR_REF, hi_v[m]);
      pins(16'h0600, 16'h0000, 16'h0000);
      rd_chk(`ADDR_REF, lo_v[m]);
    end
    wr_reg(`ADDR_SERIAL_CMD, 32'h0000_3000);
    d = 16'h0400 + 16'($urandom % 32'h7C00);
    f = 16'h0400 + 16'($urandom % 32'h7C00);
    tbl = '{32'h0000_1111, 32'(d), 32'h0000_3000, 32'(f)};
    for (int s = 0; s < 4; s++) begin
      wr_reg(`ADDR_CTRL, 32'(s));
      pins(16'h1111, d, f);
      rd_chk(`ADDR_STATUS, st(tbl[s][15:0], 1'b0));
    end
    pins(16'h1111, d, 16'hA000);
    rd_chk(`ADDR_STATUS, st(16'h8000, 1'b0));
    wr_reg(`ADDR_CTRL, 32'h0000_0002);
    wr_reg(`ADDR_SERIAL_CMD, 32'h0000_9000);
    idle(8);
    rd_chk(`ADDR_STATUS, st(16'h8000, 1'b0));
    wr_reg(`ADDR_CTRL, 32'h0000_0000);
    pins(16'h2000, 16'h0000, 16'h0000);
    idle(600);
    rd_chk(`ADDR_DUTY_OUT, 32'h0000_2000);
    pins(16'h0100, 16'h0000, 16'h0000);
    idle(4);
    rd_chk(`ADDR_DUTY_OUT, 32'h0000_0000);
    // Surge guard on: the fall must now be stepped, not a jump
    wr_reg(`ADDR_CTRL, 32'h0000_0010);
    pins(16'h2000, 16'h0000, 16'h0000);
    idle(600);
    rd_chk(`ADDR_DUTY_OUT, 32'h0000_2000);
    pins(16'h0800, 16'h0000, 16'h0000);
    @(negedge ref_clk_i);
    checks++;
    if (duty_out <= 16'h0800 || $isunknown(duty_out)) begin
      n_mismatch++;
      $display("BAD t=%0t got=%h exp=%h", $time, duty_out, 16'h0800);
    end
    idle(450);
    @(negedge ref_clk_i);
    port_chk(32'(duty_out), 32'h0000_0800);
    port_chk(32'(duty_cmd), 32'h0000_0800);
    port_chk(act_ref, 32'h0000_0800);
    port_chk(32'(stopped), 32'h0000_0000);
    @(posedge ref_clk_i);
    // Upper write bits are dropped; values keep the checker's assumptions
    for (int i = 0; i < 11; i++) begin
      wr_reg(8'(4 * i), 32'hFFFF_0000 | rst_v[i]);
      rd_chk(8'(4 * i), rst_v[i]);
    end
    idle(3);
    if (exp_q.size() != 0) n_mismatch++;
    report_and_stop();
  end
endmodule
